//--- pkg/dcs_cfg.svh
// timing counts and field codes of the command sequencer
// assumes a 100 MHz core clock; included by its bare name
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH

`define DCS_CLK_PS 10000
`define DCS_TRFC_NS 110
`define DCS_TRFC_CYC ((`DCS_TRFC_NS * 1000 + `DCS_CLK_PS - 1) / `DCS_CLK_PS)
`define DCS_TREFI_NS 7800
`define DCS_REF_POSTPONE 9
`define DCS_REF_MAX_CYC ((`DCS_REF_POSTPONE * `DCS_TREFI_NS * 1000) / `DCS_CLK_PS)

`define DCS_BL_FIXED8 2'h0
`define DCS_BL_OTF 2'h1
`define DCS_BL_FIXED4 2'h2

`define DCS_BC4_LAST 2'h1
`define DCS_BL8_LAST 2'h3

`define DCS_MR0_BANK 3'h0

`endif

//--- pkg/dcs_pkg.sv
// types of the command sequencer
// takes nothing from dcs_cfg.svh; command and state codes are literal here
package dcs_pkg;

    typedef enum logic [3:0] {
        DCS_CMD_NOP = 4'h7,
        DCS_CMD_ACT = 4'h3,
        DCS_CMD_RD = 4'h5,
        DCS_CMD_WR = 4'h4,
        DCS_CMD_REF = 4'h1,
        DCS_CMD_PRE = 4'h2,
        DCS_CMD_MRS = 4'h0,
        DCS_CMD_ZQ = 4'h6
    } dcs_cmd_t;

    typedef enum logic [2:0] {
        DCS_ST_IDLE = 3'h1,
        DCS_ST_READ = 3'h2,
        DCS_ST_WRITE = 3'h4
    } dcs_state_t;

endpackage

//--- hw/dcs_fifo.sv
// small synchronous fifo holding scheduled bursts
// assumes one clock, asynchronous active-high reset
`timescale 1ns/10ps
module dcs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,              // core clock
    input wire logic sys_rst_i,          // async reset
    input wire logic in_valid_i,         // write request
    output logic in_ready_o,             // space free
    input wire logic [WIDTH-1:0] in_data_i, // write word
    output logic out_valid_o,            // word present
    input wire logic out_ready_i,        // pop request
    output logic [WIDTH-1:0] out_data_o  // head word
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    wire [AW-1:0] next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;

    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // head word registered, with write-through when the fifo runs dry
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready_o <= 1'b1;
            out_valid_o <= 1'b0;
            out_data_o <= '0;
        end
        else
        begin
            wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            in_ready_o <= (next_count != DEPTH[AW:0]);
            out_valid_o <= (next_count != '0);
            out_data_o <= (push && wr_ptr == next_rd_ptr) ? in_data_i : mem[next_rd_ptr];
        end
    end
endmodule

//--- hw/dcs_top.sv
// command sequencer of the dram: burst length, latency, refresh spacing, odt window
// assumes command pins from the controller's domain, sampled on clk_i
// Behaviour
// - mode field 10, or field 01 with a12 low, gives a four-beat chopped burst
// - mode field 00, or field 01 with a12 high, gives a full eight-beat burst
// - on-the-fly mode takes a12 afresh for every read and write
// - write latency is additive latency plus cas write latency
// - odt sync/async transition window lasts write latency minus one cycle
`timescale 1ns/10ps
`include "dcs_cfg.svh"
module dcs_top #(
    parameter int REF_MAX_CYC = `DCS_REF_MAX_CYC,
    parameter int QDEPTH = 8
) (
    input wire logic clk_i,          // core clock
    input wire logic sys_rst_i,      // async reset
    input wire logic cs_n_i,         // chip select, low active
    input wire logic ras_n_i,        // row strobe, low active
    input wire logic cas_n_i,        // column strobe, low active
    input wire logic we_n_i,         // write enable, low active
    input wire logic cke_i,          // clock enable
    input wire logic [2:0] ba_i,     // bank address
    input wire logic [12:0] addr_i,  // address, a12 chooses otf burst
    input wire logic [3:0] cas_lat_i,  // cas latency
    input wire logic [3:0] add_lat_i,  // additive latency
    input wire logic [3:0] cwl_i,      // cas write latency
    output logic rd_burst_o,         // read data driven
    output logic wr_burst_o,         // write data captured
    output logic burst8_o,           // current burst is eight beats
    output logic odt_async_o,        // odt in transition window
    output logic rfc_viol_o,         // command inside refresh cycle
    output logic refi_viol_o,        // refresh interval overrun
    output logic q_ready_o           // burst queue has room
);
    localparam int TRFC_CYC = `DCS_TRFC_CYC;
    localparam int QW = 8;

    function automatic logic is_bl8(input logic [1:0] field, input logic a12);
        is_bl8 = (field == `DCS_BL_FIXED8) || (field == `DCS_BL_OTF && a12);
    endfunction

    function automatic logic [5:0] lat_sum(input logic [3:0] x, input logic [3:0] y);
        lat_sum = {2'h0, x} + {2'h0, y};
    endfunction

    // ==========================================================
    // pin synchronisers
    localparam int SW = 4 + 1 + 3 + 13 + 12;
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    wire [SW-1:0] pins = {cs_n_i, ras_n_i, cas_n_i, we_n_i, cke_i, ba_i, addr_i, cas_lat_i, add_lat_i, cwl_i};

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            sync1 <= {4'hf, 1'b1, {(SW-5){1'b0}}};
            sync2 <= {4'hf, 1'b1, {(SW-5){1'b0}}};
        end
        else
        begin
            sync1 <= pins;
            sync2 <= sync1;
        end
    end

    wire [3:0] cmd_bits = sync2[SW-1 -: 4];
    wire cke = sync2[SW-5];
    wire [2:0] ba = sync2[SW-6 -: 3];
    wire [12:0] addr = sync2[SW-9 -: 13];
    wire [3:0] cl = sync2[11:8];
    wire [3:0] al = sync2[7:4];
    wire [3:0] cwl = sync2[3:0];

    // ==========================================================
    // command decode
    wire cmd_sel = !cmd_bits[3];
    wire [3:0] cmd_code = {1'b0, cmd_bits[2:0]};
    wire is_rd = cmd_sel && cmd_code == dcs_pkg::DCS_CMD_RD;
    wire is_wr = cmd_sel && cmd_code == dcs_pkg::DCS_CMD_WR;
    wire is_ref = cmd_sel && cmd_code == dcs_pkg::DCS_CMD_REF && cke;
    wire is_mr0 = cmd_sel && cmd_code == dcs_pkg::DCS_CMD_MRS && ba == `DCS_MR0_BANK;
    wire is_busy_cmd = cmd_sel && cmd_code != dcs_pkg::DCS_CMD_NOP;
    wire [5:0] rl = lat_sum(cl, al);
    wire [5:0] wl = lat_sum(al, cwl);

    logic [1:0] bl_field;
    logic [5:0] now;

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            bl_field <= `DCS_BL_FIXED8;
            now <= '0;
        end
        else
        begin
            bl_field <= is_mr0 ? addr[1:0] : bl_field;
            now <= now + 6'h1;
        end
    end

    // ==========================================================
    // burst queue: {write, eight beats, due cycle}
    wire push_bl8 = is_bl8(bl_field, addr[12]);
    wire [5:0] push_due = now + (is_wr ? wl : rl);
    wire [QW-1:0] push_word = {is_wr, push_bl8, push_due};
    wire head_valid;
    wire [QW-1:0] head;
    wire head_wr = head[7];
    wire head_bl8 = head[6];
    wire [5:0] late = now - head[5:0];

    dcs_pkg::dcs_state_t state;
    logic [1:0] beat_left;
    wire engine_free = state == dcs_pkg::DCS_ST_IDLE || beat_left == 2'h0;
    wire start = head_valid && !late[5] && engine_free;

    dcs_fifo #(
        .WIDTH(QW),
        .DEPTH(QDEPTH)
    ) u_queue (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(is_rd || is_wr),
        .in_ready_o(q_ready_o),
        .in_data_i(push_word),
        .out_valid_o(head_valid),
        .out_ready_i(start),
        .out_data_o(head)
    );

    // ==========================================================
    // burst engine, two beats per clock
    wire [1:0] next_beat = head_bl8 ? `DCS_BL8_LAST : `DCS_BC4_LAST;

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state <= dcs_pkg::DCS_ST_IDLE;
            beat_left <= 2'h0;
            rd_burst_o <= 1'b0;
            wr_burst_o <= 1'b0;
            burst8_o <= 1'b0;
        end
        else if (start)
        begin
            state <= head_wr ? dcs_pkg::DCS_ST_WRITE : dcs_pkg::DCS_ST_READ;
            beat_left <= next_beat;
            rd_burst_o <= !head_wr;
            wr_burst_o <= head_wr;
            burst8_o <= head_bl8;
        end
        else if (beat_left != 2'h0)
        begin
            beat_left <= beat_left - 2'h1;
        end
        else
        begin
            state <= dcs_pkg::DCS_ST_IDLE;
            rd_burst_o <= 1'b0;
            wr_burst_o <= 1'b0;
            burst8_o <= 1'b0;
        end
    end

    // ==========================================================
    // refresh spacing watch
    logic [7:0] rfc_cnt;
    logic [15:0] refi_cnt;
    wire rfc_hit = rfc_cnt != 8'h0 && is_busy_cmd;
    wire refi_hit = refi_cnt == REF_MAX_CYC[15:0];

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rfc_cnt <= 8'h0;
            refi_cnt <= 16'h0;
            rfc_viol_o <= 1'b0;
            refi_viol_o <= 1'b0;
        end
        else
        begin
            rfc_cnt <= is_ref ? 8'(TRFC_CYC - 1) : (rfc_cnt != 8'h0 ? rfc_cnt - 8'h1 : 8'h0);
            refi_cnt <= is_ref ? 16'h0 : (refi_hit ? refi_cnt : refi_cnt + 16'h1);
            rfc_viol_o <= rfc_viol_o || rfc_hit;
            refi_viol_o <= refi_viol_o || refi_hit;
        end
    end

    // ==========================================================
    // odt transition window on cke edges
    logic cke_q;
    logic [5:0] odt_cnt;
    wire cke_edge = cke != cke_q;
    wire [5:0] anpd = wl - 6'h1;

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cke_q <= 1'b1;
            odt_cnt <= 6'h0;
            odt_async_o <= 1'b0;
        end
        else
        begin
            cke_q <= cke;
            if (cke_edge)
            begin
                odt_cnt <= anpd;
                odt_async_o <= anpd != 6'h0;
            end
            else if (odt_cnt != 6'h0)
            begin
                odt_cnt <= odt_cnt - 6'h1;
                odt_async_o <= odt_cnt != 6'h1;
            end
        end
    end

    // ==========================================================
    // checks
    sequence s_bl8_run;
        rd_burst_o [*4];
    endsequence

    sequence s_bc4_run;
        rd_burst_o [*2];
    endsequence

    chk_bc4_fixed: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (is_rd || is_wr) && bl_field == `DCS_BL_FIXED4 |-> !push_bl8)
        else $error("fixed chop field gave eight beats");
    chk_bl8_fixed: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (is_rd || is_wr) && bl_field == `DCS_BL_FIXED8 |-> push_bl8)
        else $error("fixed eight field gave chop");
    chk_otf_a12: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (is_rd || is_wr) && bl_field == `DCS_BL_OTF |-> push_bl8 == addr[12])
        else $error("otf burst ignores a12");
    chk_wr_lat: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        is_wr |-> push_due == 6'(now + al + cwl))
        else $error("write latency wrong");
    chk_rd_lat: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        is_rd |-> push_due == 6'(now + cl + al))
        else $error("read latency wrong");
    chk_rd_bl8: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        start && !head_wr && head_bl8 |=> s_bl8_run)
        else $error("eight beat read too short");
    chk_rd_bc4: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        start && !head_wr && !head_bl8 |=> s_bc4_run ##1 (!rd_burst_o || $past(start)))
        else $error("chopped read wrong length");
    chk_rfc_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rfc_hit |=> rfc_viol_o)
        else $error("command inside refresh cycle not flagged");
    chk_ref_gap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !refi_viol_o |-> refi_cnt <= REF_MAX_CYC[15:0])
        else $error("refresh overrun not flagged");
    chk_odt_window: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cke_edge && anpd == 6'h2 |=> odt_async_o ##1 odt_async_o ##1 (!odt_async_o || $past(cke_edge)))
        else $error("odt window length wrong");
endmodule

//--- dv/dcs_ctrl_model.sv
// controller-side model driving the command pins of the sequencer
// assumes the bench calls its tasks just after a rising edge
`timescale 1ns/10ps
module dcs_ctrl_model (
    input wire logic clk_i,      // core clock
    output logic cs_n_o,         // chip select, low active
    output logic ras_n_o,        // row strobe, low active
    output logic cas_n_o,        // column strobe, low active
    output logic we_n_o,         // write enable, low active
    output logic cke_o,          // clock enable
    output logic [2:0] ba_o,     // bank address
    output logic [12:0] addr_o   // address
);
    initial
    begin
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'h7;
        cke_o = 1'b1;
        ba_o = 3'h0;
        addr_o = 13'h0;
    end
    // a12 carries the per-command burst choice
    task automatic issue(input dcs_pkg::dcs_cmd_t cmd, input logic [12:0] a);
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} = cmd;
        addr_o = a;
        @(posedge clk_i);
        #1;
    endtask
    // nop with the address bits inverted
    task automatic idle(input int n);
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'h7;
        addr_o = ~addr_o;
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic refresh(input int gap);
        issue(dcs_pkg::DCS_CMD_REF, 13'h0);
        idle(gap);
    endtask
    // bank stays until the next call
    task automatic set_bank(input logic [2:0] b);
        ba_o = b;
    endtask
    // entry only from nop, never from read or write
    task automatic set_cke(input logic v);
        cke_o = v;
    endtask
endmodule

//--- dv/dcs_top_tb.sv
// self-checking bench of the command sequencer
// assumes dcs_ctrl_model drives the pins; bursts are kept apart except in the queue-full run, monitor off
`timescale 1ns/10ps
module dcs_top_tb;
    localparam int REFMAX = 400;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cs_n, ras_n, cas_n, we_n, cke;
    logic [2:0] ba;
    logic [12:0] addr;
    logic [3:0] cl = 4'h5;
    logic [3:0] al = 4'h0;
    logic [3:0] cwl = 4'h5;
    logic rd_burst, wr_burst, burst8, odt_async, rfc_viol, refi_viol, q_ready;
    int errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int hi = 0;
    int cur = 0;
    int n, r;
    logic mon_en = 1'b1;
    logic prev = 1'b0;
    logic full;
    int exp_q[$];
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;
    dcs_ctrl_model i_ctrl (.clk_i(clk_i), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n),
        .cke_o(cke), .ba_o(ba), .addr_o(addr));
    dcs_top #(.REF_MAX_CYC(REFMAX), .QDEPTH(8)) i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n),
        .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .cke_i(cke), .ba_i(ba), .addr_i(addr),
        .cas_lat_i(cl), .add_lat_i(al), .cwl_i(cwl), .rd_burst_o(rd_burst), .wr_burst_o(wr_burst),
        .burst8_o(burst8), .odt_async_o(odt_async), .rfc_viol_o(rfc_viol), .refi_viol_o(refi_viol),
        .q_ready_o(q_ready));
    // ==========================================
    // checking helpers
    function automatic bit ok(input logic c);
        cmp_count++;
        return c === 1'b1;
    endfunction
    task automatic fail(input string m);
        errors++;
        $display("Error %0t: %s", $time, m);
    endtask
    task automatic tally_and_finish;
        if (errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ==========================================
    // stimulus helpers
    task automatic op(input logic wr, input logic a12, input logic b8, input int gap);
        int lat;
        lat = wr ? al + cwl : cl + al;
        exp_q.push_back(((cyc + lat + 3) << 3) | (wr << 2) | (b8 << 1));
        i_ctrl.set_bank(3'($urandom_range(7)));
        i_ctrl.issue(wr ? dcs_pkg::DCS_CMD_WR : dcs_pkg::DCS_CMD_RD, {a12, 12'h0});
        i_ctrl.idle(gap);
    endtask
    task automatic mode(input logic [2:0] b, input logic [1:0] f);
        i_ctrl.set_bank(b);
        i_ctrl.issue(dcs_pkg::DCS_CMD_MRS, {11'h0, f});
        i_ctrl.idle(4);
    endtask
    task automatic wait_rd(input logic v);
        for (int i = 0; i < 200 && rd_burst !== v; i++) @(posedge clk_i);
        #1;
        if (!ok(rd_burst === v)) fail("read burst wait ran out");
    endtask
    // ==========================================
    // burst monitor
    always @(negedge clk_i)
    begin
        if (mon_en && (rd_burst | wr_burst) === 1'b1 && !prev)
        begin
            hi = 1;
            if (!ok(exp_q.size() > 0)) fail("unexpected burst");
            else
            begin
                cur = exp_q.pop_front();
                if (!ok(cyc == (cur >> 3))) fail("burst start time");
                if (!ok({wr_burst, burst8} === 2'(cur >> 1))) fail("burst kind");
            end
        end
        else if ((rd_burst | wr_burst) === 1'b1)
            hi++;
        else if (mon_en && prev && !ok(hi == (cur[1] ? 4 : 2)))
            fail("burst length");
        prev = (rd_burst | wr_burst) === 1'b1;
    end
    // ==========================================
    // main sequence
    initial
    begin
        void'($urandom(32'hac38));
        repeat (12) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        if (!ok({rd_burst, wr_burst, burst8, odt_async, rfc_viol, refi_viol, q_ready} === 7'h01)) fail("reset values");
        i_ctrl.refresh(12);
        mode(3'h0, 2'h1);
        op(0, 1, 1, 7);
        op(0, 0, 0, 7);
        op(1, 1, 1, 7);
        op(1, 0, 0, 7);
        repeat (6)
        begin
            r = $urandom_range(3);
            cl = 4'(5 + $urandom_range(4));
            al = 4'($urandom_range(4));
            cwl = 4'(5 + $urandom_range(3));
            i_ctrl.idle(4);
            op(r[0], r[1], r[1], 1);
            i_ctrl.idle(12);
        end
        cl = 4'h5;
        al = 4'h0;
        cwl = 4'h5;
        mode(3'h0, 2'h2);
        op(0, 1, 0, 8);
        op(1, 1, 0, 8);
        mode(3'h0, 2'h0);
        op(0, 0, 1, 8);
        mode(3'h5, 2'h2);
        op(0, 0, 1, 8);
        al = 4'h4;
        i_ctrl.idle(4);
        op(1, 0, 1, 20);
        if (!ok(exp_q.size() == 0)) fail("bursts missing");
        al = 4'h0;
        i_ctrl.refresh(12);
        for (int w = 3; w < 7; w += 3)
        begin
            cwl = 4'(w);
            i_ctrl.idle(4);
            for (int v = 0; v < 2; v++)
            begin
                i_ctrl.set_cke(v[0]);
                n = 0;
                repeat (20) @(negedge clk_i) n += (odt_async === 1'b1);
                if (!ok(n == w - 1)) fail("odt transition window");
                @(posedge clk_i);
                #1;
            end
        end
        cwl = 4'h5;
        i_ctrl.refresh(12);
        mon_en = 1'b0;
        cl = 4'hf;
        al = 4'hf;
        full = 1'b0;
        i_ctrl.idle(4);
        repeat (12)
        begin
            i_ctrl.issue(dcs_pkg::DCS_CMD_RD, 13'h1000);
            full |= (q_ready === 1'b0);
        end
        i_ctrl.idle(1);
        if (!ok(full)) fail("burst queue never full");
        wait_rd(1'b1);
        wait_rd(1'b0);
        if (!ok(q_ready === 1'b1)) fail("burst queue not drained");
        mon_en = 1'b1;
        cl = 4'h5;
        al = 4'h0;
        i_ctrl.refresh(10);
        i_ctrl.issue(dcs_pkg::DCS_CMD_ACT, 13'h0);
        i_ctrl.idle(4);
        if (!ok(rfc_viol === 1'b0)) fail("act after refresh cycle flagged");
        i_ctrl.refresh(9);
        i_ctrl.issue(dcs_pkg::DCS_CMD_ACT, 13'h0);
        i_ctrl.idle(4);
        if (!ok(rfc_viol === 1'b1)) fail("act inside refresh cycle missed");
        i_ctrl.refresh(REFMAX - 4);
        if (!ok(refi_viol === 1'b0)) fail("refresh interval flagged early");
        for (int i = 0; i < 12 && refi_viol !== 1'b1; i++) @(posedge clk_i);
        #1;
        if (!ok(refi_viol === 1'b1)) fail("refresh interval overrun missed");
        sys_rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        @(posedge clk_i);
        #1;
        if (!ok({rd_burst, wr_burst, burst8, odt_async, rfc_viol, refi_viol, q_ready} === 7'h01))
            fail("mid-run reset values");
        n = 0;
        repeat (6) @(negedge clk_i) n += (odt_async === 1'b1);
        if (!ok(n == 0)) fail("false odt window after reset");
        @(posedge clk_i);
        #1;
        op(0, 1, 1, 12);
        if (!ok(exp_q.size() == 0)) fail("burst lost after reset");
        tally_and_finish();
    end
endmodule
